// ### add_and_shift_alu_ops_test.sv
/* Self-checking bench for asalu_core.
   Assumes the register file model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module add_and_shift_alu_ops_test;
    import asalu_pkg::*;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, op_valid_i = 1'b0, ptr_sel_i = 1'b0, dest_sel_i = 1'b0;
    asalu_op_e   op_i = ASALU_OP_NONE;
    logic [7:0]  literal_i = 8'h00, reg_rdata_i, reg_wdata_o, acc_o;
    logic [5:0]  ptr_literal_i = 6'h00;
    logic [6:0]  reg_addr_i = 7'h00, reg_waddr_o;
    logic [15:0] ptr0, ptr1;
    logic        reg_we_o, carry_flag_o, digit_carry_flag_o, zero_flag_o;
    int          mismatches = 0, checks_done = 0;
    wire logic [15:0] st = {acc_o, 5'h00, carry_flag_o, digit_carry_flag_o, zero_flag_o};
    asalu_core asalu_core_i (.clk_sys_i, .reset_i, .op_valid_i, .op_i, .literal_i, .ptr_literal_i, .ptr_sel_i,
        .dest_sel_i, .reg_addr_i, .reg_rdata_i, .reg_we_o, .reg_waddr_o, .reg_wdata_o, .acc_o,
        .indirect_pointer0_o(ptr0), .indirect_pointer1_o(ptr1), .carry_flag_o, .digit_carry_flag_o, .zero_flag_o);
    asalu_regfile_model asalu_regfile_model_i (.clk_sys_i, .reg_addr_i, .reg_we_i(reg_we_o),
        .reg_waddr_i(reg_waddr_o), .reg_wdata_i(reg_wdata_o), .reg_rdata_o(reg_rdata_i));
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input asalu_op_e o, input logic [7:0] l, input logic s, input logic d, input logic [6:0] a);
        @(negedge clk_sys_i);
        op_valid_i = 1'b1;
        op_i = o;
        literal_i = l;
        ptr_literal_i = l[5:0];
        ptr_sel_i = s;
        dest_sel_i = d;
        reg_addr_i = a;
    endtask : go
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk_sys_i);
            op_valid_i = 1'b0;
        end
    endtask : idle
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // Flag layout in st: acc, then carry, digit carry, zero in the low bits
    task automatic test_literal;
        go(ASALU_OP_ADD_LITERAL_INTO_ACC, 8'hff, 1'b0, 1'b0, 7'h00);
        idle(1);
        chk(st, 16'hff00);
        go(ASALU_OP_ADD_LITERAL_INTO_ACC, 8'h01, 1'b0, 1'b0, 7'h00);
        idle(1);
        chk(st, 16'h0007);
        go(ASALU_OP_ADD_LITERAL_INTO_ACC, 8'h8f, 1'b0, 1'b0, 7'h00);
        go(ASALU_OP_ADD_LITERAL_INTO_ACC, 8'h81, 1'b0, 1'b0, 7'h00);
        go(ASALU_OP_AND_LITERAL_INTO_ACC, 8'h0f, 1'b0, 1'b0, 7'h00);
        idle(1);
        chk(st, 16'h0007);
    endtask : test_literal
    task automatic test_pointer;
        go(ASALU_OP_POINTER_ADD_LITERAL, 8'h3f, 1'b1, 1'b0, 7'h00);
        idle(1);
        chk(ptr1, 16'hffff);
        go(ASALU_OP_POINTER_ADD_LITERAL, 8'h01, 1'b1, 1'b0, 7'h00);
        go(ASALU_OP_POINTER_ADD_LITERAL, 8'h20, 1'b0, 1'b0, 7'h00);
        idle(1);
        chk(ptr1, 16'h0000);
        chk(ptr0, 16'hffe0);
        chk(st, 16'h0007);
    endtask : test_pointer
    task automatic test_register;
        go(ASALU_OP_ADD_LITERAL_INTO_ACC, 8'hf0, 1'b0, 1'b0, 7'h00);
        go(ASALU_OP_AND_ACC_WITH_REG, 8'h00, 1'b0, 1'b1, 7'h7f);
        idle(1);
        chk({reg_we_o, reg_waddr_o, reg_wdata_o}, 16'hff50);
        idle(1);
        chk({8'h00, asalu_regfile_model_i.mem[127]}, 16'h0050);
        chk(st, 16'hf000);
        go(ASALU_OP_ADD_ACC_WITH_REG, 8'h00, 1'b0, 1'b0, 7'h7f);
        go(ASALU_OP_ADD_ACC_WITH_REG, 8'h00, 1'b0, 1'b1, 7'h00);
        idle(2);
        chk(st, 16'h4004);
        chk({8'h00, asalu_regfile_model_i.mem[0]}, 16'h003f);
    endtask : test_register
    task automatic test_shift_carry;
        go(ASALU_OP_ARITH_SHIFT_RIGHT, 8'h00, 1'b0, 1'b0, 7'h03);
        go(ASALU_OP_ARITH_SHIFT_RIGHT, 8'h00, 1'b0, 1'b1, 7'h03);
        idle(2);
        chk(st, 16'hc004);
        chk({8'h00, asalu_regfile_model_i.mem[3]}, 16'h00c0);
        go(ASALU_OP_ADD_LITERAL_INTO_ACC, 8'h40, 1'b0, 1'b0, 7'h00);
        go(ASALU_OP_ADD_ACC_REG_CARRY, 8'h00, 1'b0, 1'b0, 7'h7f);
        go(ASALU_OP_ADD_ACC_REG_CARRY, 8'h00, 1'b0, 1'b1, 7'h00);
        idle(2);
        chk(st, 16'h5102);
        chk({8'h00, asalu_regfile_model_i.mem[0]}, 16'h0090);
    endtask : test_shift_carry
    task automatic test_refused;
        go(ASALU_OP_NONE, 8'hff, 1'b1, 1'b1, 7'h00);
        @(negedge clk_sys_i);
        op_valid_i = 1'b0;
        op_i = ASALU_OP_ADD_LITERAL_INTO_ACC;
        idle(2);
        chk(st, 16'h5102);
        chk({8'h00, asalu_regfile_model_i.mem[0]}, 16'h0090);
    endtask : test_refused
    initial begin
        asalu_regfile_model_i.mem[127] = 8'h5a;
        asalu_regfile_model_i.mem[0] = 8'hff;
        asalu_regfile_model_i.mem[3] = 8'h81;
        repeat (20) @(negedge clk_sys_i);
        reset_i = 1'b0;
        test_literal();
        test_pointer();
        test_register();
        test_shift_carry();
        test_refused();
        report_and_stop();
    end
    initial begin
        #25000;
        mismatches++;
        report_and_stop();
    end
endmodule : add_and_shift_alu_ops_test
`default_nettype wire

// ### asalu_core.sv
/*
 * Datapath for pointer add, literal/register AND and ADD, add with carry
 * and arithmetic right shift, with carry, digit carry and zero flags.
 * Assumes the decoder presents one operation per cycle, and the register
 * file supplies the addressed register's value in the same cycle.
 */
//
// Contract
// - Pointer add sign-extends 6-bit literal, flags untouched.
// - Pointer sum wraps modulo 65536 silently.
// - AND literal into accumulator, zero only.
// - Add literal into accumulator; carry, digit, zero.
// - AND with register; zero only; destination select.
// - Add with register; carry, digit, zero; destination.
// - Shift right, keep bit 7, bit 0 to carry.
// - Shift updates carry and zero; destination select.
// - Add accumulator, register, carry; all three flags.
`timescale 1ns/1ps
`default_nettype none
module asalu_core (
    // Clock and reset
    input  wire logic                              clk_sys_i,
    input  wire logic                              reset_i,
    // Operation from the decoder
    input  wire logic                              op_valid_i,
    input  wire asalu_pkg::asalu_op_e              op_i,
    input  wire logic [asalu_pkg::DATA_W-1:0]      literal_i,
    input  wire logic [asalu_pkg::LIT6_W-1:0]      ptr_literal_i,
    input  wire logic                              ptr_sel_i,
    input  wire logic                              dest_sel_i,
    input  wire logic [asalu_pkg::REG_ADDR_W-1:0]  reg_addr_i,
    // Register file read data
    input  wire logic [asalu_pkg::DATA_W-1:0]      reg_rdata_i,
    // Register file write-back
    output logic                                   reg_we_o,
    output logic [asalu_pkg::REG_ADDR_W-1:0]       reg_waddr_o,
    output logic [asalu_pkg::DATA_W-1:0]           reg_wdata_o,
    // Architectural state
    output logic [asalu_pkg::DATA_W-1:0]           acc_o,
    output logic [asalu_pkg::PTR_W-1:0]            indirect_pointer0_o,
    output logic [asalu_pkg::PTR_W-1:0]            indirect_pointer1_o,
    output logic                                   carry_flag_o,
    output logic                                   digit_carry_flag_o,
    output logic                                   zero_flag_o
);
    import asalu_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [DATA_W-1:0]     acc;
    logic [PTR_W-1:0]      ptr [PTR_COUNT];
    logic                  carry_flag;
    logic                  digit_carry_flag;
    logic                  zero_flag;
    logic                  reg_we;
    logic [REG_ADDR_W-1:0] reg_waddr;
    logic [DATA_W-1:0]     reg_wdata;

    // ************************************************************
    // Next values
    // ************************************************************
    logic [DATA_W-1:0]     next_acc;
    logic [PTR_W-1:0]      next_ptr [PTR_COUNT];
    logic                  next_carry_flag;
    logic                  next_digit_carry_flag;
    logic                  next_zero_flag;
    logic                  next_reg_we;
    logic [REG_ADDR_W-1:0] next_reg_waddr;
    logic [DATA_W-1:0]     next_reg_wdata;

    // ************************************************************
    // Next-state computation
    // ************************************************************
    // Operands and sums are built every cycle, valid or not;
    // the strobe only decides whether they are kept.
    // Only a 1-bit pointer select is decoded; a third pointer needs a wider one.
    logic [DATA_W-1:0]     operand_b;
    logic                  carry_in;
    logic [DATA_W:0]       sum;
    logic [NIBBLE_MSB+1:0] low_sum;
    logic [DATA_W-1:0]     result;
    logic                  is_add;
    logic                  is_logic;
    logic                  to_reg;
    logic [PTR_W-1:0]      ptr_offset;

    always_comb begin
        next_acc              = acc;
        next_ptr              = ptr;
        next_carry_flag       = carry_flag;
        next_digit_carry_flag = digit_carry_flag;
        next_zero_flag        = zero_flag;
        next_reg_we           = 1'b0;
        // Address tracks the decoder; the strobe alone qualifies it
        next_reg_waddr        = reg_addr_i;
        // Write data holds its last value between writes
        next_reg_wdata        = reg_wdata;
        is_add                = 1'b0;
        is_logic              = 1'b0;
        to_reg                = 1'b0;
        carry_in              = 1'b0;
        operand_b             = reg_rdata_i;
        result                = acc;

        // Literal operations other than pointer add always target the accumulator
        case (op_i)
            ASALU_OP_ADD_LITERAL_INTO_ACC,
            ASALU_OP_AND_LITERAL_INTO_ACC: operand_b = literal_i;
            default:                       operand_b = reg_rdata_i;
        endcase
        // Registered carry in, so a chain of these sees the previous op's carry
        if (op_i == ASALU_OP_ADD_ACC_REG_CARRY) begin
            carry_in = carry_flag;
        end

        // One shared adder; digit carry taken from a separate nibble sum
        sum     = {1'b0, acc} + {1'b0, operand_b} + {{DATA_W{1'b0}}, carry_in};
        low_sum = {1'b0, acc[NIBBLE_MSB:0]} + {1'b0, operand_b[NIBBLE_MSB:0]}
                  + {{(NIBBLE_MSB+1){1'b0}}, carry_in};

        // Literal is sign-extended; 16-bit add drops the carry so it wraps
        ptr_offset = {{(PTR_W-LIT6_W){ptr_literal_i[LIT6_W-1]}}, ptr_literal_i};

        if (op_valid_i) begin
            case (op_i)
                ASALU_OP_POINTER_ADD_LITERAL: begin
                    // Pointer add leaves every flag as it was
                    next_ptr[ptr_sel_i] = ptr[ptr_sel_i] + ptr_offset;
                end
                ASALU_OP_AND_LITERAL_INTO_ACC: begin
                    result   = acc & operand_b;
                    is_logic = 1'b1;
                end
                ASALU_OP_ADD_LITERAL_INTO_ACC: begin
                    result = sum[DATA_W-1:0];
                    is_add = 1'b1;
                end
                ASALU_OP_AND_ACC_WITH_REG: begin
                    result   = acc & operand_b;
                    is_logic = 1'b1;
                    to_reg   = (dest_sel_i == DEST_REG);
                end
                ASALU_OP_ADD_ACC_WITH_REG,
                ASALU_OP_ADD_ACC_REG_CARRY: begin
                    result = sum[DATA_W-1:0];
                    is_add = 1'b1;
                    to_reg = (dest_sel_i == DEST_REG);
                end
                ASALU_OP_ARITH_SHIFT_RIGHT: begin
                    result          = {reg_rdata_i[DATA_W-1], reg_rdata_i[DATA_W-1:1]};
                    // Digit carry is not touched by the shift
                    next_carry_flag = reg_rdata_i[0];
                    is_logic        = 1'b1;
                    to_reg          = (dest_sel_i == DEST_REG);
                end
                default: begin
                end
            endcase

            // Flag update is shared by every arithmetic and logic op
            if (is_add) begin
                next_carry_flag       = sum[DATA_W];
                next_digit_carry_flag = low_sum[NIBBLE_MSB+1];
            end
            if (is_add || is_logic) begin
                next_zero_flag = (result == '0);
                // A register destination leaves the accumulator as it was
                if (to_reg) begin
                    next_reg_we    = 1'b1;
                    next_reg_wdata = result;
                end else begin
                    next_acc = result;
                end
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Synchronous reset; every register runs on every edge
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            acc              <= ACC_RESET;
            ptr[0]           <= PTR_RESET;
            ptr[1]           <= PTR_RESET;
            carry_flag       <= FLAG_RESET;
            digit_carry_flag <= FLAG_RESET;
            zero_flag        <= FLAG_RESET;
            reg_we           <= 1'b0;
            reg_waddr        <= '0;
            reg_wdata        <= ACC_RESET;
        end else begin
            acc              <= next_acc;
            ptr              <= next_ptr;
            carry_flag       <= next_carry_flag;
            digit_carry_flag <= next_digit_carry_flag;
            zero_flag        <= next_zero_flag;
            reg_we           <= next_reg_we;
            reg_waddr        <= next_reg_waddr;
            reg_wdata        <= next_reg_wdata;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // All outputs come straight from flops, so no input reaches them directly
    assign acc_o               = acc;
    assign indirect_pointer0_o = ptr[0];
    assign indirect_pointer1_o = ptr[1];
    assign carry_flag_o        = carry_flag;
    assign digit_carry_flag_o  = digit_carry_flag;
    assign zero_flag_o         = zero_flag;
    assign reg_we_o            = reg_we;
    assign reg_waddr_o         = reg_waddr;
    assign reg_wdata_o         = reg_wdata;
endmodule : asalu_core
`default_nettype wire

// ### asalu_monitor.sv
/* Port checker bound to asalu_core.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module asalu_monitor
    import asalu_pkg::*;
(
    input wire logic        clk_sys_i, reset_i, op_valid_i, ptr_sel_i, dest_sel_i,
    input wire asalu_op_e   op_i,
    input wire logic [7:0]  literal_i, reg_rdata_i, reg_wdata_o, acc_o,
    input wire logic [5:0]  ptr_literal_i,
    input wire logic [6:0]  reg_addr_i, reg_waddr_o,
    input wire logic [15:0] indirect_pointer0_o,
    input wire logic        reg_we_o, carry_flag_o, digit_carry_flag_o, zero_flag_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire logic [15:0] lit_ext = {{10{ptr_literal_i[5]}}, ptr_literal_i};
    wire logic        rd0     = reg_rdata_i[0];
    wire logic        wr      = op_valid_i && dest_sel_i && op_i inside {ASALU_OP_AND_ACC_WITH_REG,
        ASALU_OP_ADD_ACC_WITH_REG, ASALU_OP_ARITH_SHIFT_RIGHT, ASALU_OP_ADD_ACC_REG_CARRY};
    chk_ptr_sum: assert property (op_valid_i && op_i == ASALU_OP_POINTER_ADD_LITERAL && !ptr_sel_i
        |=> indirect_pointer0_o == $past(indirect_pointer0_o) + $past(lit_ext) && $stable(carry_flag_o))
        else $error("pointer sum wrong");
    chk_and_lit: assert property (op_valid_i && op_i == ASALU_OP_AND_LITERAL_INTO_ACC
        |=> acc_o == ($past(acc_o) & $past(literal_i)) && $stable(carry_flag_o)) else $error("and literal wrong");
    chk_add_lit: assert property (op_valid_i && op_i == ASALU_OP_ADD_LITERAL_INTO_ACC
        |=> {carry_flag_o, acc_o} == $past(acc_o) + $past(literal_i)) else $error("add literal wrong");
    chk_shift_carry: assert property (op_valid_i && op_i == ASALU_OP_ARITH_SHIFT_RIGHT
        |=> carry_flag_o == $past(rd0) && $stable(digit_carry_flag_o)) else $error("shift carry wrong");
    chk_carry_sum: assert property (op_valid_i && op_i == ASALU_OP_ADD_ACC_REG_CARRY && !dest_sel_i
        |=> {carry_flag_o, acc_o} == $past(acc_o) + $past(reg_rdata_i) + $past(carry_flag_o))
        else $error("add with carry wrong");
    chk_write_back: assert property (wr |=> reg_we_o && reg_waddr_o == $past(reg_addr_i))
        else $error("write back missing");
    chk_idle_hold: assert property (!op_valid_i |=> !reg_we_o && $stable(acc_o) && $stable(indirect_pointer0_o))
        else $error("idle cycle changed state");
    chk_zero_track: assert property (reg_we_o |-> zero_flag_o == (reg_wdata_o == 8'h00))
        else $error("zero flag wrong");
endmodule : asalu_monitor
bind asalu_core asalu_monitor asalu_monitor_i (.clk_sys_i, .reset_i, .op_valid_i, .ptr_sel_i, .dest_sel_i, .op_i,
    .literal_i, .reg_rdata_i, .reg_wdata_o, .acc_o, .ptr_literal_i, .reg_addr_i, .reg_waddr_o, .indirect_pointer0_o,
    .reg_we_o, .carry_flag_o, .digit_carry_flag_o, .zero_flag_o);
`default_nettype wire

// ### asalu_pkg.sv
/*
 * Shared constants and operation codes for the add-and-shift datapath.
 * Assumes the instruction decoder drives these codes on the same clock.
 */
package asalu_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PTR_W       = 16;
    localparam int unsigned LIT6_W      = 6;
    localparam int unsigned REG_ADDR_W  = 7;
    localparam int unsigned PTR_COUNT   = 2;
    localparam int unsigned NIBBLE_MSB  = 3;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [15:0] PTR_RESET   = 16'h0000;
    localparam logic        FLAG_RESET  = 1'b0;
    localparam logic        DEST_ACC    = 1'b0;
    localparam logic        DEST_REG    = 1'b1;

    typedef enum logic [2:0] {
        ASALU_OP_NONE,
        ASALU_OP_POINTER_ADD_LITERAL,
        ASALU_OP_AND_LITERAL_INTO_ACC,
        ASALU_OP_ADD_LITERAL_INTO_ACC,
        ASALU_OP_AND_ACC_WITH_REG,
        ASALU_OP_ADD_ACC_WITH_REG,
        ASALU_OP_ARITH_SHIFT_RIGHT,
        ASALU_OP_ADD_ACC_REG_CARRY
    } asalu_op_e;
endpackage : asalu_pkg

// ### asalu_regfile_model.sv
/* Register file model on the far side of the write-back port.
   Assumes the bench preloads the entries that it reads. */
`timescale 1ns/1ps
`default_nettype none
module asalu_regfile_model (
    input  wire logic       clk_sys_i,
    input  wire logic [6:0] reg_addr_i,
    input  wire logic       reg_we_i,
    input  wire logic [6:0] reg_waddr_i,
    input  wire logic [7:0] reg_wdata_i,
    output wire logic [7:0] reg_rdata_o
);
    logic [7:0] mem [128];
    assign reg_rdata_o = mem[reg_addr_i];
    // Write lands one edge after the pulse, so no bypass to a reader in that cycle
    always @(posedge clk_sys_i) if (reg_we_i) mem[reg_waddr_i] <= reg_wdata_i;
endmodule : asalu_regfile_model
`default_nettype wire
